// *** logic/dgn_defines.svh ***
// register offsets, field positions, codes and reset values of the diagnosis block
`ifndef DGN_DEFINES_SVH
`define DGN_DEFINES_SVH
`define DGN_OFS_MASKED 8'h62
`define DGN_OFS_FLAGS 8'h64
`define DGN_OFS_STATUS 8'h66
`define DGN_OFS_ENABLE 8'h74
`define DGN_RST_REG 16'h0000
// error flag bit positions
`define DGN_B_SIG 0
`define DGN_B_DRV 7
`define DGN_B_EXC 8
`define DGN_B_INL 9
`define DGN_B_INH 10
`define DGN_B_ECC 11
`define DGN_B_AU 12
`define DGN_B_V5 13
`define DGN_B_LCC 14
// enable register bit positions
`define DGN_B_POST_LOGIC 0
`define DGN_B_POST_ROM 11
`define DGN_B_POST_RAM 14
`define DGN_B_CYC_DIS 15
// self-test status layout: done in 5:0, fail in 13:8
`define DGN_B_FAIL 8
`define DGN_B_EE_FAIL 11
`define DGN_B_AU_FAIL 12
`define DGN_B_CROM_FAIL 13
// which flag bits come from analog detectors and which from local logic
`define DGN_AFE_MASK 16'h279e
`define DGN_DIG_MASK 16'h4860
// bits that take part in masking: bit 0 always on, 11/14/15 never
`define DGN_MASK_FORCE_ON 16'h0001
`define DGN_MASK_FORCE_OFF 16'hc800
// codes
`define DGN_FAST_ERR 12'hffa
`define DGN_SLOW_FYY 12'hf00
`define DGN_SLOW_EXC 12'ha00
`define DGN_SLOW_INP 12'ha01
`define DGN_SLOW_EECYC 12'ha02
`define DGN_SLOW_AU 12'ha03
`define DGN_SLOW_INIT 12'h003
`define DGN_SLOW_NONE 12'h000
`define DGN_ALERT 8'h07
`define DGN_ALERT_CMDLESS 8'h0f
`endif

// *** logic/dgn_pkg.sv ***
// types shared by the diagnosis and error control block
package dgn_pkg;
  typedef enum logic [1:0] {DGN_OPM, DGN_CFM, DGN_DGM} dgn_mode_e;
  typedef enum logic [2:0] {
    ST_LOAD, ST_START, ST_WAIT, ST_EEFAIL, ST_RESET, ST_RUN
  } dgn_state_e;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } dgn_reg_req_s;
  // self-test engine results: logic, rom, ram, eeprom, arith, cyclic rom
  typedef struct packed {
    logic [5:0] done;
    logic [5:0] fail;
  } dgn_test_res_s;
endpackage : dgn_pkg

// *** logic/dgn_sync.sv ***
// two-stage synchroniser for asynchronous detector levels
`timescale 1ns/1ps
module dgn_sync #(
  parameter int W = 16
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  // first stage feeds only the second
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : dgn_sync

// *** logic/dgn_code_sel.sv ***
// slow-channel diagnostic code selection by priority
`timescale 1ns/1ps
`include "dgn_defines.svh"
module dgn_code_sel
  import dgn_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [15:0] masked_i,
  input wire logic ee_post_fail_i,
  input wire logic ee_cyc_fail_i,
  output logic [11:0] code_o
);
  logic [11:0] code_d;
  // init error first, then the 0xFyy group, then the single codes
  always_comb begin
    code_d = `DGN_SLOW_NONE;
    if (ee_post_fail_i) begin
      code_d = `DGN_SLOW_INIT;
    end else if (|masked_i[7:0]) begin
      code_d = `DGN_SLOW_FYY | {4'h0, masked_i[7:0]};
    end else if (masked_i[`DGN_B_EXC]) begin
      code_d = `DGN_SLOW_EXC;
    end else if (masked_i[`DGN_B_INL] || masked_i[`DGN_B_INH]) begin
      code_d = `DGN_SLOW_INP;
    end else if (ee_cyc_fail_i) begin
      code_d = `DGN_SLOW_EECYC;
    end else if (masked_i[`DGN_B_AU]) begin
      code_d = `DGN_SLOW_AU;
    end
  end
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      code_o <= `DGN_SLOW_NONE;
    end else begin
      code_o <= code_d;
    end
  end
endmodule : dgn_code_sel

// *** logic/dgn_error_ctrl.sv ***
// diagnosis and error control: flags, masking, power-on tests, output fault handling
`timescale 1ns/1ps
`include "dgn_defines.svh"
module dgn_error_ctrl
  import dgn_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire dgn_reg_req_s reg_req_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_ack_o,
  input wire logic [15:0] ee_enable_i,
  input wire dgn_mode_e mode_i,
  input wire logic bist_cmd_i,
  input wire dgn_test_res_s test_res_i,
  output logic [5:0] test_start_o,
  output logic cyclic_run_o,
  input wire logic [15:0] afe_err_i,
  input wire logic [15:0] dig_err_i,
  input wire logic slow_code_sent_i,
  output logic sys_reset_o,
  output logic post_busy_o,
  output logic pin_drive_en_o,
  output logic pin_force_high_o,
  output logic nibble_err_o,
  output logic fast_err_o,
  output logic [11:0] fast_code_o,
  output logic [11:0] slow_code_o,
  input wire logic cmdless_i,
  output logic alert_o,
  output logic [7:0] alert_byte_o
);
  dgn_state_e state_q;
  logic [1:0] idx_q;
  logic skip_post_q;
  logic ee_post_fail_q;
  logic [15:0] enable_q;
  logic [15:0] flags_q;
  logic [15:0] status_q;
  logic [15:0] afe_s;
  logic [15:0] flags_rd;
  logic [15:0] masked;
  logic [15:0] err_set;
  logic [15:0] st_set;
  logic [5:0] acc_done;
  logic [5:0] acc_fail;
  logic lcc_evt;
  logic opm;
  logic v5_float;
  logic drv_live;
  logic post_fail;

  // reads whether a given power-on test is selected; eeprom always runs
  function automatic logic post_sel(input logic [1:0] i, input logic [15:0] en);
    case (i)
      2'd0: post_sel = en[`DGN_B_POST_LOGIC];
      2'd1: post_sel = en[`DGN_B_POST_ROM];
      2'd2: post_sel = en[`DGN_B_POST_RAM];
      default: post_sel = 1'b1;
    endcase
  endfunction : post_sel

  // analog detector levels are asynchronous to this clock
  dgn_sync #(.W(16)) u_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .async_i(afe_err_i & `DGN_AFE_MASK),
    .sync_o(afe_s)
  );

  assign opm = (mode_i == DGN_OPM);
  assign lcc_evt = dig_err_i[`DGN_B_LCC];
  assign drv_live = afe_s[`DGN_B_DRV];

  // results are accepted from engines that may legally run now
  // cyclic results ignored when disabled
  always_comb begin
    acc_done = test_res_i.done;
    acc_fail = test_res_i.fail;
    if (!cyclic_run_o) begin
      acc_done[5] = 1'b0;
      acc_fail[5] = 1'b0;
      if (state_q != ST_RUN || opm) begin
        acc_done[4:3] = test_res_i.done[4:3] & {1'b0, state_q == ST_WAIT};
        acc_fail[4:3] = test_res_i.fail[4:3] & {1'b0, state_q == ST_WAIT};
      end
    end
  end

  // continuous tests only in operation and not disabled
  assign cyclic_run_o = opm && (state_q == ST_RUN) && !enable_q[`DGN_B_CYC_DIS];

  // power-on sequence, soft re-initialisation and self reset
  // power-on and commanded test sequencing
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_q <= ST_LOAD;
      idx_q <= 2'd0;
      skip_post_q <= 1'b0;
      ee_post_fail_q <= 1'b0;
      test_start_o <= 6'h00;
    end else begin
      test_start_o <= 6'h00;
      if (lcc_evt) begin
        state_q <= ST_RESET;
        skip_post_q <= 1'b1;
      end else begin
        case (state_q)
          ST_LOAD: begin
            idx_q <= 2'd0;
            ee_post_fail_q <= 1'b0;
            state_q <= skip_post_q ? ST_RUN : ST_START;
            skip_post_q <= 1'b0;
          end
          ST_START: begin
            // selection by enable bits 0, 11, 14
            if (post_sel(idx_q, enable_q)) begin
              test_start_o[idx_q] <= 1'b1;
              state_q <= ST_WAIT;
            end else begin
              idx_q <= idx_q + 2'd1;
            end
          end
          ST_WAIT: begin
            if (test_res_i.done[idx_q]) begin
              if (test_res_i.fail[idx_q] && idx_q == 2'd3) begin
                ee_post_fail_q <= 1'b1;
                state_q <= ST_EEFAIL;
              end else if (test_res_i.fail[idx_q]) begin
                state_q <= ST_RESET;
              end else if (idx_q == 2'd3) begin
                state_q <= ST_RUN;
              end else begin
                idx_q <= idx_q + 2'd1;
                state_q <= ST_START;
              end
            end
          end
          ST_EEFAIL: begin
            if (slow_code_sent_i) begin
              state_q <= ST_RESET;
            end
          end
          ST_RESET: begin
            state_q <= ST_LOAD;
          end
          ST_RUN: begin
            if (bist_cmd_i && !opm) begin
              test_start_o <= 6'h1f;
            end
          end
          default: begin
            state_q <= ST_LOAD;
          end
        endcase
      end
    end
  end

  // self reset pulse, also on flow inconsistency
  assign sys_reset_o = (state_q == ST_RESET);
  assign post_busy_o = (state_q != ST_RUN);
  assign post_fail = (state_q == ST_WAIT) && test_res_i.done[idx_q]
                     && test_res_i.fail[idx_q] && idx_q != 2'd3;

  // enable register loaded from eeprom copy at each initialisation
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      enable_q <= `DGN_RST_REG;
    end else if (state_q == ST_LOAD) begin
      enable_q <= ee_enable_i;
    end else if (reg_req_i.wr && reg_req_i.addr == `DGN_OFS_ENABLE) begin
      enable_q <= reg_req_i.wdata;
    end
  end

  // sticky error flags; bits 0 and 12 are mirrors of status bits
  // correction events accepted in every mode
  assign err_set = (afe_s | (dig_err_i & `DGN_DIG_MASK));
  // write stores, a new event wins over the clear
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      flags_q <= `DGN_RST_REG;
    end else if (reg_req_i.wr && reg_req_i.addr == `DGN_OFS_FLAGS) begin
      flags_q <= reg_req_i.wdata | err_set;
    end else begin
      flags_q <= flags_q | err_set;
    end
  end

  // self-test status: done in 5:0, fail in 13:8
  // done flags, fail flags
  assign st_set = {2'b00, acc_fail, 2'b00, acc_done};
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      status_q <= `DGN_RST_REG;
    end else if (reg_req_i.wr && reg_req_i.addr == `DGN_OFS_STATUS) begin
      status_q <= (reg_req_i.wdata | st_set) & 16'h3f3f;
    end else begin
      status_q <= status_q | st_set;
    end
  end

  always_comb begin
    flags_rd = flags_q;
    flags_rd[15] = 1'b0;
    flags_rd[`DGN_B_SIG] = status_q[`DGN_B_CROM_FAIL] | status_q[`DGN_B_EE_FAIL];
    flags_rd[`DGN_B_AU] = status_q[`DGN_B_AU_FAIL];
  end

  // masking uses the enables; bit 0 is always active
  assign masked = flags_rd & ((enable_q | `DGN_MASK_FORCE_ON) & ~`DGN_MASK_FORCE_OFF);

  // register reads answer one cycle later; unmapped reads give zero
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 16'h0000;
      reg_ack_o <= 1'b0;
    end else begin
      reg_ack_o <= reg_req_i.rd | reg_req_i.wr;
      case (reg_req_i.addr)
        `DGN_OFS_MASKED: reg_rdata_o <= masked;
        `DGN_OFS_FLAGS: reg_rdata_o <= flags_rd;
        `DGN_OFS_STATUS: reg_rdata_o <= status_q;
        `DGN_OFS_ENABLE: reg_rdata_o <= enable_q;
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  // live supply fault floats the pin, released at once
  assign v5_float = afe_s[`DGN_B_V5] && enable_q[`DGN_B_V5];
  // pin floats during power-on tests and their repeats
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      pin_drive_en_o <= 1'b0;
      pin_force_high_o <= 1'b0;
    end else begin
      pin_drive_en_o <= (state_q == ST_RUN || state_q == ST_EEFAIL) && !v5_float;
      pin_force_high_o <= 1'b0;
    end
  end

  // status nibble and fast channel; supply bit handled by floating the pin
  // nibble error from masked code
  // 4090 while the driver fault is live
  // latched driver flag alone leaves fast data valid
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      nibble_err_o <= 1'b0;
      fast_err_o <= 1'b0;
    end else begin
      nibble_err_o <= (|(masked & 16'h1f7f)) || (drv_live && enable_q[`DGN_B_DRV])
                      || ee_post_fail_q;
      fast_err_o <= (|(masked & 16'h1f7f)) || (drv_live && enable_q[`DGN_B_DRV])
                    || ee_post_fail_q;
    end
  end
  assign fast_code_o = `DGN_FAST_ERR;

  // slow code priority, 0xFyy bit 0 from cyclic rom
  dgn_code_sel u_code (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .masked_i(masked & {16{opm}} & ~{15'h0000, !status_q[`DGN_B_CROM_FAIL]}),
    .ee_post_fail_i(ee_post_fail_q),
    .ee_cyc_fail_i(opm && status_q[`DGN_B_EE_FAIL]),
    .code_o(slow_code_o)
  );

  // alert for command answers in operation
  // get-signal alert, command-less variant
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      alert_o <= 1'b0;
      alert_byte_o <= 8'h00;
    end else begin
      alert_o <= opm && (|masked);
      alert_byte_o <= cmdless_i ? `DGN_ALERT_CMDLESS : `DGN_ALERT;
    end
  end

  // checks
  logic [11:0] ref_slow;
  assign ref_slow = `DGN_SLOW_FYY | 12'h080;
  a_flow_reset: assert property (@(posedge clock_i) disable iff (!rstn_i)
    lcc_evt |=> sys_reset_o ##1 (state_q == ST_LOAD) ##1 (state_q == ST_RUN))
    else $error("flow error did not reset without tests");
  a_flow_flag: assert property (@(posedge clock_i) disable iff (!rstn_i)
    lcc_evt && !reg_req_i.wr |=> flags_q[`DGN_B_LCC])
    else $error("flow error flag not set");
  a_post_reset: assert property (@(posedge clock_i) disable iff (!rstn_i)
    post_fail |=> sys_reset_o ##1 !sys_reset_o)
    else $error("power-on failure without reset pulse");
  a_pin_float: assert property (@(posedge clock_i) disable iff (!rstn_i)
    post_busy_o && state_q != ST_EEFAIL |=> !pin_drive_en_o)
    else $error("pin driven during power-on tests");
  a_supply_float: assert property (@(posedge clock_i) disable iff (!rstn_i)
    v5_float |=> !pin_drive_en_o)
    else $error("pin driven during supply fault");
  a_driver_fast: assert property (@(posedge clock_i) disable iff (!rstn_i)
    drv_live && enable_q[`DGN_B_DRV] |=> fast_err_o && nibble_err_o)
    else $error("driver fault not sent as 4090");
  a_driver_slow: assert property (@(posedge clock_i) disable iff (!rstn_i)
    opm && masked == 16'h0080 && !ee_post_fail_q |=> slow_code_o == ref_slow)
    else $error("driver fault slow code wrong");
  a_masked_and: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (masked & ~enable_q & 16'hfffe) == 16'h0000)
    else $error("masked code holds a disabled bit");
  a_cyclic_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
    enable_q[`DGN_B_CYC_DIS] |-> !cyclic_run_o)
    else $error("cyclic tests run while disabled");
  a_sticky_flag: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(flags_q[`DGN_B_V5]) && !reg_req_i.wr |=> flags_q[`DGN_B_V5] [*2])
    else $error("supply flag not sticky");
  a_alert_byte: assert property (@(posedge clock_i) disable iff (!rstn_i)
    cmdless_i |=> alert_byte_o == 8'h0f)
    else $error("command-less alert byte wrong");
endmodule : dgn_error_ctrl

// *** verification/dgn_engine_model.sv ***
// behavioural self-test engines that answer start pulses after a fixed delay
`timescale 1ns/1ps
module dgn_engine_model
  import dgn_pkg::*;
#(
  parameter int LAT = 4
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [5:0] start_i,
  input wire logic [5:0] kick_i,
  input wire logic [5:0] fail_mask_i,
  output dgn_test_res_s res_o
);
  logic [5:0] pipe_q [LAT];

  // delay line; kick stands for a cyclic run that the engine starts by itself
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < LAT; i++) begin
        pipe_q[i] <= 6'h00;
      end
    end else begin
      pipe_q[0] <= start_i | kick_i;
      for (int i = 1; i < LAT; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  // fail is only ever shown together with done, never on its own
  assign res_o.done = pipe_q[LAT-1];
  assign res_o.fail = pipe_q[LAT-1] & fail_mask_i;
endmodule : dgn_engine_model

// *** verification/dgn_error_ctrl_tb.sv ***
// self-checking bench for the diagnosis and error control block
`timescale 1ns/1ps
`include "dgn_defines.svh"
module dgn_error_ctrl_tb
  import dgn_pkg::*;
;
  logic clock_i, rstn_i, bist_cmd, cmdless, sent, ack, cyc_run, sys_rst, busy, drv, fhi;
  logic nib, ferr, alert;
  logic [15:0] ee_en, afe, dig, rdata, rv, seq;
  logic [11:0] fcode, scode;
  logic [7:0] abyte;
  logic [5:0] start, kick, fmask;
  dgn_reg_req_s req;
  dgn_mode_e mode;
  dgn_test_res_s res;
  int fail_count, samples_checked, n_rst, n_drv, n_st0;

  dgn_error_ctrl i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .ee_enable_i(ee_en), .mode_i(mode),
    .bist_cmd_i(bist_cmd), .test_res_i(res), .test_start_o(start), .cyclic_run_o(cyc_run),
    .afe_err_i(afe), .dig_err_i(dig), .slow_code_sent_i(sent), .sys_reset_o(sys_rst),
    .post_busy_o(busy), .pin_drive_en_o(drv), .pin_force_high_o(fhi), .nibble_err_o(nib),
    .fast_err_o(ferr), .fast_code_o(fcode), .slow_code_o(scode), .cmdless_i(cmdless),
    .alert_o(alert), .alert_byte_o(abyte));
  dgn_engine_model i_eng (.clock_i(clock_i), .rstn_i(rstn_i), .start_i(start),
    .kick_i(kick), .fail_mask_i(fmask), .res_o(res));

  // 40 mhz clock
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick

  // one register cycle; the request stands for exactly one taking edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clock_i);
    req <= '{wr: w, rd: ~w, addr: a, wdata: wd};
    @(posedge clock_i);
    req <= '0;
    @(negedge clock_i);
    while (ack !== 1'b1 && n < 4) begin
      n++;
      @(negedge clock_i);
    end
    chk("ack", 16'h0001, {15'h0000, ack});
    rv = rdata;
    // return on a rising edge so that callers drive their next inputs there
    @(posedge clock_i);
  endtask : acc

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    chk("rdata", exp, rv);
  endtask : rdc

  task automatic pulse_dig(input logic [15:0] v);
    @(posedge clock_i);
    dig <= v;
    @(posedge clock_i);
    dig <= 16'h0000;
  endtask : pulse_dig

  task automatic do_reset;
    @(posedge clock_i);
    rstn_i <= 1'b0;
    tick(2);
    rstn_i <= 1'b1;
  endtask : do_reset

  // sampled at the falling edge so that launching edges have settled
  task automatic watch(input int n, input logic until_run);
    int i;
    i = 0;
    n_rst = 0;
    n_drv = 0;
    n_st0 = 0;
    seq = 16'h0000;
    repeat (n) begin
      @(negedge clock_i);
      i++;
      n_rst += int'(sys_rst === 1'b1);
      n_drv += int'(drv === 1'b1);
      for (int k = 0; k < 4; k++) begin
        if (start[k] === 1'b1) begin
          seq = {seq[11:0], 4'(k)};
          n_st0 += int'(k == 0);
        end
      end
      if (until_run && i > 8 && busy === 1'b0) break;
    end
    @(posedge clock_i);
  endtask : watch

  task automatic t_post;
    ee_en <= 16'h4801;
    do_reset();
    watch(300, 1'b1);
    chk("post order", 16'h0123, seq);
    rdc(`DGN_OFS_STATUS, 16'h000f);
    rdc(`DGN_OFS_ENABLE, 16'h4801);
    rdc(`DGN_OFS_FLAGS, `DGN_RST_REG);
    chk("pin drive", 16'h0001, {15'h0000, drv});
    chk("force high", 16'h0000, {15'h0000, fhi});
    chk("no alert", 16'h0007, {7'h00, alert, abyte});
  endtask : t_post

  task automatic t_cmd;
    mode <= DGN_CFM;
    acc(1'b1, `DGN_OFS_STATUS, 16'h0000);
    @(posedge clock_i);
    bist_cmd <= 1'b1;
    @(posedge clock_i);
    bist_cmd <= 1'b0;
    watch(40, 1'b0);
    chk("cmd start", 16'h0001, 16'(n_st0 != 0));
    acc(1'b0, `DGN_OFS_STATUS, 16'h0000);
    chk("cmd done", 16'h0001, rv & 16'h0101);
    mode <= DGN_OPM;
  endtask : t_cmd

  task automatic t_codes;
    logic [3:0] bits [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'ha};
    logic [11:0] codes [8] = '{12'hf02, 12'hf04, 12'hf08, 12'hf10, 12'hf80, 12'ha00,
      12'ha01, 12'ha01};
    acc(1'b1, `DGN_OFS_ENABLE, 16'h37fe);
    for (int i = 0; i < 8; i++) begin
      afe <= 16'h0001 << bits[i];
      tick(6);
      chk("slow code", {4'h0, codes[i]}, {4'h0, scode});
      chk("nibble err", 16'h0011, {11'h000, nib, 3'h0, ferr});
      chk("fast code", {4'h0, `DGN_FAST_ERR}, {4'h0, fcode});
      afe <= 16'h0000;
      tick(4);
      acc(1'b1, `DGN_OFS_FLAGS, 16'h0000);
    end
    rdc(`DGN_OFS_FLAGS, 16'h0000);
    acc(1'b1, `DGN_OFS_ENABLE, 16'h0000);
    afe <= 16'h0080;
    tick(6);
    chk("nibble masked", 16'h0000, {15'h0000, nib});
    afe <= 16'h0000;
    tick(4);
    acc(1'b1, `DGN_OFS_MASKED, 16'hffff);
    rdc(`DGN_OFS_MASKED, 16'h0000);
    acc(1'b1, `DGN_OFS_ENABLE, 16'h0080);
    rdc(`DGN_OFS_MASKED, 16'h0080);
    rdc(`DGN_OFS_FLAGS, 16'h0080);
    chk("latched driver", 16'h0f80, {3'h0, ferr, scode});
    acc(1'b1, `DGN_OFS_FLAGS, 16'h0000);
    rdc(8'h70, 16'h0000);
  endtask : t_codes

  task automatic t_supply;
    acc(1'b1, `DGN_OFS_ENABLE, 16'h2000);
    afe <= 16'h2000;
    tick(6);
    chk("pin float", 16'h0000, {15'h0000, drv});
    chk("alert", 16'h0107, {7'h00, alert, abyte});
    cmdless <= 1'b1;
    tick(3);
    chk("cmdless alert", 16'h010f, {7'h00, alert, abyte});
    afe <= 16'h0000;
    cmdless <= 1'b0;
    tick(5);
    chk("pin back", 16'h0001, {15'h0000, drv});
    rdc(`DGN_OFS_FLAGS, 16'h2000);
    acc(1'b1, `DGN_OFS_FLAGS, 16'h0000);
  endtask : t_supply

  task automatic t_digital;
    acc(1'b1, `DGN_OFS_ENABLE, 16'h0800);
    pulse_dig(16'h0800);
    tick(4);
    rdc(`DGN_OFS_FLAGS, 16'h0800);
    chk("no code", 16'h0000, {nib, 3'h0, scode});
    pulse_dig(16'h4000);
    watch(300, 1'b1);
    chk("self reset", 16'h0001, 16'(n_rst != 0));
    chk("no post", 16'h0000, 16'(n_st0));
    rdc(`DGN_OFS_FLAGS, 16'h4800);
    acc(1'b1, `DGN_OFS_FLAGS, 16'h0000);
  endtask : t_digital

  task automatic t_arith;
    fmask <= 6'h30;
    acc(1'b1, `DGN_OFS_ENABLE, 16'h1000);
    acc(1'b1, `DGN_OFS_STATUS, 16'h0000);
    chk("cyclic run", 16'h0001, {15'h0000, cyc_run});
    kick <= 6'h10;
    @(posedge clock_i);
    kick <= 6'h00;
    tick(8);
    chk("arith code", 16'h0a03, {4'h0, scode});
    rdc(`DGN_OFS_STATUS, 16'h1010);
    rdc(`DGN_OFS_FLAGS, 16'h1000);
    kick <= 6'h20;
    @(posedge clock_i);
    kick <= 6'h00;
    tick(8);
    chk("signature code", 16'h0f01, {4'h0, scode});
    rdc(`DGN_OFS_STATUS, 16'h3030);
    rdc(`DGN_OFS_FLAGS, 16'h1001);
    acc(1'b1, `DGN_OFS_STATUS, 16'h0000);
    fmask <= 6'h08;
    kick <= 6'h08;
    @(posedge clock_i);
    kick <= 6'h00;
    tick(8);
    chk("cyclic eeprom code", 16'h0a02, {4'h0, scode});
    acc(1'b1, `DGN_OFS_ENABLE, 16'h8000);
    acc(1'b1, `DGN_OFS_STATUS, 16'h0000);
    acc(1'b1, `DGN_OFS_FLAGS, 16'h0000);
    chk("cyclic off", 16'h0000, {15'h0000, cyc_run});
    kick <= 6'h10;
    @(posedge clock_i);
    kick <= 6'h00;
    tick(8);
    rdc(`DGN_OFS_STATUS, 16'h0000);
  endtask : t_arith

  task automatic t_postfail;
    fmask <= 6'h01;
    ee_en <= 16'h0001;
    do_reset();
    watch(200, 1'b0);
    chk("post fail reset", 16'h0001, 16'(n_rst != 0));
    chk("pin held off", 16'h0000, 16'(n_drv));
    fmask <= 6'h00;
    watch(300, 1'b1);
    // the pin enable is registered one cycle behind the run state
    tick(1);
    chk("pin after pass", 16'h0001, {15'h0000, drv});
  endtask : t_postfail

  task automatic t_eefail;
    fmask <= 6'h08;
    ee_en <= 16'h0000;
    do_reset();
    watch(40, 1'b0);
    chk("init code", 16'h1003, {3'h0, nib, scode});
    fmask <= 6'h00;
    sent <= 1'b1;
    @(posedge clock_i);
    sent <= 1'b0;
    watch(300, 1'b1);
    chk("init reset", 16'h0001, 16'(n_rst != 0));
  endtask : t_eefail

  // stimulus at time zero, 16 cycles of reset, then the scenarios
  initial begin
    fail_count = 0;
    samples_checked = 0;
    rstn_i = 1'b0;
    req = '0;
    ee_en = 16'h4801;
    mode = DGN_OPM;
    bist_cmd = 1'b0;
    cmdless = 1'b0;
    sent = 1'b0;
    afe = 16'h0000;
    dig = 16'h0000;
    kick = 6'h00;
    fmask = 6'h00;
    tick(16);
    rstn_i <= 1'b1;
    t_post();
    t_cmd();
    t_codes();
    t_supply();
    t_digital();
    t_arith();
    t_postfail();
    t_eefail();
    stop_test();
  end

  // the run needs under a thousand cycles; a hang is cut off well beyond that
  initial begin
    tick(20000);
    fail_count++;
    stop_test();
  end
endmodule : dgn_error_ctrl_tb
